/* File: hw/dpt_map.svh */
// register offsets, field positions, reset values and rule summary for the dual down timer
// What this block does
// - run change takes effect at clock fall
// - stop write allows one more count
// - run bit reads 1 until halted
// - sleep holds count, resumes after
// - cascade: channel 0 borrow feeds channel 1
// - channel 0 read never latches channel 1
`ifndef DPT_MAP_SVH
`define DPT_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define DPT_ADDR_W 4
`define DPT_OFF_CTRL 4'h0
`define DPT_OFF_CNT0 4'h1
`define DPT_OFF_CNT1 4'h2
`define DPT_OFF_RLD0 4'h3
`define DPT_OFF_RLD1 4'h4
// ****************************************
// control register fields
// ****************************************
`define DPT_CTRL_RUN0 0
`define DPT_CTRL_RUN1 1
`define DPT_CTRL_OUTEN0 2
`define DPT_CTRL_OUTEN1 3
`define DPT_CTRL_CASCADE 4
// ****************************************
// reset values
// ****************************************
`define DPT_CNT_RST 8'h00
`define DPT_RLD_RST 8'h00
`endif

/* File: hw/dpt_pkg.sv */
// types shared by the dual down timer
package dpt_pkg;
	typedef logic [7:0] dpt_byte_t;
	typedef struct packed
	{
		logic casc;
		logic out_en1;
		logic out_en0;
	} dpt_cfg_s;
endpackage

/* File: hw/dpt_timer.sv */
// dual 8-bit down timer with 16-bit cascade mode
`timescale 1ns/1ps
`default_nettype none
`include "dpt_map.svh"
module dpt_timer
(
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [1:0] cnt_clk_i,
	input wire logic sleep_i,
	input wire logic [`DPT_ADDR_W-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	output logic [1:0] underflow_o,
	output logic [1:0] timer_clock_output_o
);
	// ****************************************
	// state
	// ****************************************
	dpt_pkg::dpt_byte_t cnt_reg [2];
	dpt_pkg::dpt_byte_t cnt_next [2];
	dpt_pkg::dpt_byte_t rld_reg [2];
	dpt_pkg::dpt_byte_t rld_next [2];
	logic [1:0] req_reg, req_next;
	logic [1:0] run_reg, run_next;
	logic [1:0] clk_d_reg;
	logic [1:0] uf_reg, uf_next;
	logic [1:0] timer_clock_output_reg, timer_clock_output_next;
	dpt_pkg::dpt_cfg_s cfg_reg, cfg_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [1:0] fall;
	logic [1:0] step;
	logic borrow0;
	logic [1:0] clk_d_next;

	// ****************************************
	// count clock edge detect
	// ****************************************
	// delayed copy resets low: no false fall after reset
	assign clk_d_next = cnt_clk_i;
	assign fall = clk_d_reg & ~cnt_clk_i;

	// ****************************************
	// per channel count enable and clock output
	// ****************************************
	// ch0 borrow: a step taken from zero
	assign borrow0 = step[0] && (cnt_reg[0] == 8'h00);

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			logic src_edge;
			logic out_en;

			// ch1 follows the ch0 borrow in cascade
			if (ch == 0)
			begin : g_low
				assign src_edge = fall[0];
				assign out_en = cfg_reg.out_en0;
			end
			else
			begin : g_high
				assign src_edge = cfg_reg.casc ? borrow0 : fall[1];
				assign out_en = cfg_reg.out_en1;
			end

			// sleep freezes the count
			assign step[ch] = src_edge && run_reg[ch] && !sleep_i;
			assign timer_clock_output_o[ch] = timer_clock_output_reg[ch] & out_en;
		end
	endgenerate

	// ****************************************
	// next state
	// ****************************************
	always_comb
	begin
		cnt_next = cnt_reg;
		rld_next = rld_reg;
		req_next = req_reg;
		run_next = run_reg;
		uf_next = 2'h0;
		timer_clock_output_next = timer_clock_output_reg;
		cfg_next = cfg_reg;

		// ****************************************
		// counting, reload and run transitions
		// ****************************************
		// reload and underflow pulse at zero
		for (int i = 0; i < 2; i++)
		begin
			if (step[i])
			begin
				if (cnt_reg[i] == 8'h00)
				begin
					cnt_next[i] = rld_reg[i];
					uf_next[i] = 1'b1;
					timer_clock_output_next[i] = ~timer_clock_output_reg[i];
				end
				else
					cnt_next[i] = cnt_reg[i] - 8'h01;
			end
			// stop at a fall still counts once, since step used old run
			if (fall[i] && !sleep_i)
				run_next[i] = req_reg[i];
		end

		// ****************************************
		// control and reload writes
		// ****************************************
		// run requests wait for the next fall
		if (wr_i)
		begin
			unique case (addr_i)
				`DPT_OFF_CTRL:
				begin
					req_next[0] = wdata_i[`DPT_CTRL_RUN0];
					req_next[1] = wdata_i[`DPT_CTRL_RUN1];
					cfg_next.out_en0 = wdata_i[`DPT_CTRL_OUTEN0];
					cfg_next.out_en1 = wdata_i[`DPT_CTRL_OUTEN1];
					cfg_next.casc = wdata_i[`DPT_CTRL_CASCADE];
				end
				`DPT_OFF_RLD0: rld_next[0] = wdata_i;
				`DPT_OFF_RLD1: rld_next[1] = wdata_i;
				default: ;
			endcase
		end
	end

	// ****************************************
	// read path
	// ****************************************
	// registered: data stands the cycle after the strobe
	always_comb
	begin
		rdata_next = 8'h00;
		if (rd_i)
		begin
			unique case (addr_i)
				`DPT_OFF_CTRL:
				begin
					rdata_next[`DPT_CTRL_RUN0] = req_reg[0] | run_reg[0];
					rdata_next[`DPT_CTRL_RUN1] = req_reg[1] | run_reg[1];
					rdata_next[`DPT_CTRL_OUTEN0] = cfg_reg.out_en0;
					rdata_next[`DPT_CTRL_OUTEN1] = cfg_reg.out_en1;
					rdata_next[`DPT_CTRL_CASCADE] = cfg_reg.casc;
				end
				`DPT_OFF_CNT0: rdata_next = cnt_reg[0];
				`DPT_OFF_CNT1: rdata_next = cnt_reg[1];
				`DPT_OFF_RLD0: rdata_next = rld_reg[0];
				`DPT_OFF_RLD1: rdata_next = rld_reg[1];
				default: rdata_next = 8'h00;
			endcase
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge mclk_i)
	begin
		if (!resetn_i)
		begin
			cnt_reg[0] <= `DPT_CNT_RST;
			cnt_reg[1] <= `DPT_CNT_RST;
			rld_reg[0] <= `DPT_RLD_RST;
			rld_reg[1] <= `DPT_RLD_RST;
			req_reg <= 2'h0;
			run_reg <= 2'h0;
			clk_d_reg <= 2'h0;
			uf_reg <= 2'h0;
			timer_clock_output_reg <= 2'h0;
			cfg_reg <= '0;
			rdata_reg <= 8'h00;
		end
		else
		begin
			cnt_reg <= cnt_next;
			rld_reg <= rld_next;
			req_reg <= req_next;
			run_reg <= run_next;
			clk_d_reg <= clk_d_next;
			uf_reg <= uf_next;
			timer_clock_output_reg <= timer_clock_output_next;
			cfg_reg <= cfg_next;
			rdata_reg <= rdata_next;
		end
	end


	// ****************************************
	// outputs
	// ****************************************
	assign rdata_o = rdata_reg;
	assign underflow_o = uf_reg;

endmodule
`default_nettype wire

/* File: testbench/dpt_timer_asserts.sv */
// port checker for the dual down timer
`timescale 1ns/1ps
`default_nettype none
module dpt_timer_asserts
(
	input wire logic mclk_i,
	input wire logic resetn_i,
	input wire logic [1:0] cnt_clk_i,
	input wire logic sleep_i,
	input wire logic [3:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [1:0] underflow_o,
	input wire logic [1:0] timer_clock_output_o
);
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);
	rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("rdata not idle");
	bad_addr_a: assert property (rd_i && addr_i > 4'h4 |=> rdata_o == 8'h00) else $error("unmapped read");
	uf0_pulse_a: assert property (underflow_o[0] |=> !underflow_o[0]) else $error("uf0 too long");
	uf1_pulse_a: assert property (underflow_o[1] |=> !underflow_o[1]) else $error("uf1 too long");
	slp_hold_a: assert property (sleep_i[*3] |-> underflow_o == 2'b00) else $error("count in sleep");
	hi_quiet_a: assert property (cnt_clk_i[0][*4] |-> !underflow_o[0]) else $error("step without fall");
	lo_quiet_a: assert property ((!cnt_clk_i[0])[*4] |-> !underflow_o[0]) else $error("step on low");
	timer_clock_output_src_a: assert property ($changed(timer_clock_output_o) |-> |underflow_o || $past(|underflow_o) || $past(wr_i))
		else $error("timer_clock_output change");
endmodule
bind dpt_timer dpt_timer_asserts u_chk(.*);
`default_nettype wire

/* File: testbench/dpt_timer_tb_top.sv */
// self-checking bench for the dual down timer
`timescale 1ns/1ps
`default_nettype none
`include "dpt_map.svh"
module dpt_timer_tb_top;
	logic mclk_i = 0, resetn_i = 0, sleep_i = 0, wr_i = 0, rd_i = 0;
	logic [1:0] cnt_clk_i = 2'b11, rq = 0, rw = 0, underflow_o, timer_clock_output_o;
	logic [3:0] addr_i = 0;
	logic [7:0] wdata_i = 0, rdata_o, lf = 8'h40, c[2] = '{0, 0}, r[2];
	bit casc;
	int errors, check_count, cyc;
	int ufn[2], ufe[2];
	dpt_timer u_dut(.mclk_i, .resetn_i, .cnt_clk_i, .sleep_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.underflow_o, .timer_clock_output_o);
	initial forever #4 mclk_i = ~mclk_i;
	// counts underflow pulses seen on the pins
	always @(posedge mclk_i) if (resetn_i) begin ufn[0] += underflow_o[0]; ufn[1] += underflow_o[1]; end
	task check(string n, logic [7:0] got, logic [7:0] exp);
		check_count++;
		if (got !== exp) begin errors++; $display("Error %s exp %h got %h", n, exp, got); end
	endtask
	always @(posedge mclk_i) if (++cyc > 20000) begin errors++; stop_test(); end
	task stop_test;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	function logic [7:0] lfsr(logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task wr(logic [3:0] a, logic [7:0] d);
		addr_i <= a; wdata_i <= d; wr_i <= 1; @(posedge mclk_i); wr_i <= 0; @(posedge mclk_i);
	endtask
	task rd(string n, logic [3:0] a, logic [7:0] e);
		addr_i <= a; rd_i <= 1; @(posedge mclk_i); rd_i <= 0; #1;
		check(n, rdata_o, e);
		@(posedge mclk_i);
	endtask
	task ctl(logic [7:0] d);
		rw = d[1:0]; casc = d[4]; wr(`DPT_OFF_CTRL, d);
	endtask
	// n count clock falls, each followed by the expected counters
	task fall(int n);
		repeat (n) begin
			cnt_clk_i <= 2'b00; repeat (4) @(posedge mclk_i);
			cnt_clk_i <= 2'b11; repeat (4) @(posedge mclk_i);
			if (!sleep_i) begin
				if (rq[1] && (casc ? rq[0] && c[0] == 0 : 1)) begin ufe[1] += (c[1] == 0); c[1] = c[1] ? c[1] - 8'h01 : r[1]; end
				if (rq[0]) begin ufe[0] += (c[0] == 0); c[0] = c[0] ? c[0] - 8'h01 : r[0]; end
				rq = rw;
			end
		end
	endtask
	initial begin
		repeat (16) @(posedge mclk_i); resetn_i <= 1; @(posedge mclk_i);
		lf = lfsr(lf); r[0] = lf | 8'h04; lf = lfsr(lf); r[1] = lf;
		wr(`DPT_OFF_RLD0, r[0]); wr(`DPT_OFF_RLD1, r[1]); ctl(8'h05); fall(1);
		rd("cnt0", `DPT_OFF_CNT0, c[0]);
		fall(3); rd("cnt0", `DPT_OFF_CNT0, c[0]);
		rd("cnt1", `DPT_OFF_CNT1, c[1]);
		rd("hole", 4'hf, 8'h00);
		$display("run test done");
		sleep_i <= 1; fall(2); sleep_i <= 0; rd("cnt0", `DPT_OFF_CNT0, c[0]);
		fall(1); rd("cnt0", `DPT_OFF_CNT0, c[0]);
		$display("sleep test done");
		ctl(8'h04); rd("ctrl", `DPT_OFF_CTRL, 8'h05);
		fall(1); rd("cnt0", `DPT_OFF_CNT0, c[0]);
		rd("ctrl", `DPT_OFF_CTRL, 8'h04);
		fall(1); rd("cnt0", `DPT_OFF_CNT0, c[0]);
		check("uf0", 8'(ufn[0]), 8'(ufe[0]));
		check("timer_clock_output", {6'h00, timer_clock_output_o}, {7'h00, ufe[0][0]});
		$display("stop test done");
		wr(`DPT_OFF_RLD0, 8'h02); r[0] = 8'h02; ctl(8'h13); fall(int'(c[0]) + 8);
		rd("cnt0", `DPT_OFF_CNT0, c[0]);
		rd("cnt1", `DPT_OFF_CNT1, c[1]);
		ctl(8'h10); fall(1); sleep_i <= 1; fall(1); sleep_i <= 0;
		rd("cnt0", `DPT_OFF_CNT0, c[0]);
		rd("cnt1", `DPT_OFF_CNT1, c[1]);
		check("uf1", 8'(ufn[1]), 8'(ufe[1]));
		check("timer_clock_output", {6'h00, timer_clock_output_o}, 8'h00);
		$display("cascade test done");
		stop_test();
	end
endmodule
`default_nettype wire
